// >>> design/tlsp_params.svh
// Purpose: Constants for the torque limit and stall prevention block.
// Assumes: Included by bare name; definitions only.
// Notes:   Torque and current figures are in tenths of a percent.
`ifndef TLSP_PARAMS_SVH
`define TLSP_PARAMS_SVH

// ************************************************************
// Register word addresses
// ************************************************************
`define TLSP_ADDR_CTRL      4'h0
`define TLSP_ADDR_FWD_DRV   4'h1
`define TLSP_ADDR_REV_DRV   4'h2
`define TLSP_ADDR_FWD_RGN   4'h3
`define TLSP_ADDR_REV_RGN   4'h4
`define TLSP_ADDR_AFN       4'h5
`define TLSP_ADDR_GAIN      4'h6
`define TLSP_ADDR_STL_SEL   4'h7
`define TLSP_ADDR_STL_LVL   4'h8
`define TLSP_ADDR_STATUS    4'h9

// ************************************************************
// Reset values and ranges
// ************************************************************
`define TLSP_METHOD_RST     2'h0
`define TLSP_DUTY_RST       1'h1
`define TLSP_TLIM_RST       9'h0c8
`define TLSP_TLIM_MAX       9'h12c
`define TLSP_AFN_RST        5'h00
`define TLSP_GAIN_RST       12'h3e8
`define TLSP_STL_SEL_RST    2'h1
`define TLSP_STL_LVL_VT     8'h78
`define TLSP_STL_LVL_CT     8'h96
`define TLSP_STL_LVL_MIN    8'h1e
`define TLSP_STL_LVL_MAX    8'hc8

// ************************************************************
// Codes
// ************************************************************
`define TLSP_METHOD_OLV     2'h2
`define TLSP_METHOD_RSVD    2'h3
`define TLSP_AFN_STALL      5'h08
`define TLSP_AFN_POS        5'h0a
`define TLSP_AFN_NEG        5'h0b
`define TLSP_AFN_REGEN      5'h0c
`define TLSP_AFN_BOTH       5'h0f
`define TLSP_SEL_OFF        2'h0
`define TLSP_SEL_DEC2       2'h2

// ************************************************************
// Scaling
// ************************************************************
`define TLSP_PCT_SCALE      16'h000a
`define TLSP_CEIL_CT        16'h05dc
`define TLSP_CEIL_VT        16'h04b0
`define TLSP_REACCEL_HYST   16'h0014
`define TLSP_ANA_ZERO       12'h100
`define TLSP_ANA_SPAN       11'h400
`define TLSP_ANA_SHIFT      10

// ************************************************************
// Timing
// ************************************************************
`define TLSP_STALL_MS       100
`define TLSP_CLK_HZ         40000000
`define TLSP_STALL_CYCLES   (`TLSP_STALL_MS * (`TLSP_CLK_HZ / 1000))
`define TLSP_TMR_W          22

`endif

// >>> design/tlsp_pkg.sv
// Purpose: Types for the torque limit and stall prevention block.
// Assumes: Constants come from tlsp_params.svh.
// Notes:   Nothing here is imported; users write tlsp_pkg::name.
`include "tlsp_params.svh"

package tlsp_pkg;

  typedef enum logic [2:0] {
    TLSP_IDLE    = 3'b001,
    TLSP_LOWER   = 3'b010,
    TLSP_RECOVER = 3'b100
  } tlsp_stall_e_t;

  typedef struct packed {
    logic [1:0]          method;
    logic                duty;
    logic [8:0]          fwdDriveTorqueLimit;
    logic [8:0]          revDriveTorqueLimit;
    logic [8:0]          fwdRegenTorqueLimit;
    logic [8:0]          revRegenTorqueLimit;
    logic [4:0]          analogInputFunctionSelect;
    logic [11:0]         analogInputGain;
    logic [1:0]          runStallPreventionSelect;
    logic [7:0]          runStallPreventionLevel;
    logic                waitRequest;
    logic [31:0]         readData;
    logic signed [15:0]  torqueCmd;
    logic [15:0]         effLimit;
    logic                limitActive;
    tlsp_stall_e_t       stall;
    logic                stallLower;
    logic                stallReaccel;
    logic                decelTimeTwoSel;
  } tlsp_state_t;

  typedef struct packed {
    logic [`TLSP_TMR_W-1:0] count;
    logic                   expired;
  } tlsp_tmr_t;

endpackage

// >>> design/tlsp_stall_timer.sv
// Purpose: Counts consecutive cycles of stall-level overcurrent.
// Assumes: countEn comes from logic on mclk.
// Notes:   Any gap in countEn restarts the count from zero.
`timescale 1ns/1ps
`default_nettype none
`include "tlsp_params.svh"

module tlsp_stall_timer #(
  parameter int CYCLES = `TLSP_STALL_CYCLES
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic countEn,
  output logic      expired
);

  localparam logic [`TLSP_TMR_W-1:0] LIMIT = `TLSP_TMR_W'(CYCLES);

  tlsp_pkg::tlsp_tmr_t q;
  tlsp_pkg::tlsp_tmr_t d;

  always_comb begin
    d = q;
    if (!countEn) begin
      d.count   = '0;
      d.expired = 1'b0;
    end else begin
      if (q.count < LIMIT) begin
        d.count = q.count + 1'b1;
      end
      d.expired = (q.count + 1'b1) >= LIMIT;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;

  stall_time_full_a: assert property (@(posedge mclk) disable iff (!resetn)
    countEn && (q.count == LIMIT - 1'b1) |=> expired)
    else $error("stall timer missed its full count");

endmodule
`default_nettype wire

// >>> design/tlsp_torque_stall.sv
// Purpose: Clamps torque command and supervises stall prevention while running.
// Assumes: Torque, current, speed and analog inputs come from logic on mclk.
// Notes:   Registers sit on an Avalon-MM slave with one wait state.
`timescale 1ns/1ps
`default_nettype none
`include "tlsp_params.svh"

module tlsp_torque_stall #(
  parameter int STALL_CYCLES = `TLSP_STALL_CYCLES
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic [3:0]         avsAddress,
  input  wire logic               avsRead,
  input  wire logic               avsWrite,
  input  wire logic [31:0]        avsWriteData,
  output logic [31:0]             avsReadData,
  output logic                    avsWaitRequest,
  input  wire logic signed [15:0] torqueCalc,
  input  wire logic               fwdSpin,
  input  wire logic [11:0]        analogLevel,
  input  wire logic [11:0]        outputCurrent,
  input  wire logic               freqAtSet,
  output logic signed [15:0]      torqueCmd,
  output logic                    speedCtrlHold,
  output logic                    stallLower,
  output logic                    stallReaccel,
  output logic                    decelTimeTwoSel
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // The current loop is read as 64 codes per mA so the 16 mA span is a shift.
  function automatic logic [15:0] anaScale(input logic [11:0] code, input logic [11:0] gain);
    logic [10:0] span;
    logic [22:0] prod;
    span = '0;
    prod = '0;
    if (code > `TLSP_ANA_ZERO) begin
      span = (code - `TLSP_ANA_ZERO > 12'(`TLSP_ANA_SPAN)) ? `TLSP_ANA_SPAN
           : 11'(code - `TLSP_ANA_ZERO);
    end
    prod = span * gain;
    anaScale = 16'(prod >> `TLSP_ANA_SHIFT);
  endfunction

  function automatic logic [15:0] pct(input logic [8:0] p);
    pct = 16'({7'h00, p} * `TLSP_PCT_SCALE);
  endfunction

  tlsp_pkg::tlsp_state_t q;
  tlsp_pkg::tlsp_state_t d;

  logic        timerExpired;
  logic        posTorque;
  logic        regen;
  logic [15:0] torqueMag;
  logic [15:0] paramLimit;
  logic [15:0] ceiling;
  logic [15:0] analogLimit;
  logic        analogApplies;
  logic [15:0] limit;
  logic        olv;
  logic        clampNow;
  logic        stallOn;
  logic [15:0] stallLevel;
  logic [15:0] current;
  logic        overLevel;
  logic        underHyst;
  logic        busWrite;

  // ************************************************************
  // Torque limit
  // ************************************************************
  always_comb begin
    posTorque   = !torqueCalc[15];
    regen       = posTorque != fwdSpin;
    torqueMag   = torqueCalc[15] ? 16'(-torqueCalc) : 16'(torqueCalc);
    unique case ({posTorque, fwdSpin})
      2'b11:   paramLimit = pct(q.fwdDriveTorqueLimit);
      2'b10:   paramLimit = pct(q.revRegenTorqueLimit);
      2'b00:   paramLimit = pct(q.revDriveTorqueLimit);
      default: paramLimit = pct(q.fwdRegenTorqueLimit);
    endcase
    ceiling       = q.duty ? `TLSP_CEIL_VT : `TLSP_CEIL_CT;
    analogLimit   = anaScale(analogLevel, q.analogInputGain);
    analogApplies = ((q.analogInputFunctionSelect == `TLSP_AFN_POS) && posTorque)
                 || ((q.analogInputFunctionSelect == `TLSP_AFN_NEG) && !posTorque)
                 || ((q.analogInputFunctionSelect == `TLSP_AFN_REGEN) && regen)
                 || (q.analogInputFunctionSelect == `TLSP_AFN_BOTH);
    limit = min16(paramLimit, ceiling);
    if (analogApplies) begin
      limit = min16(limit, analogLimit);
    end
    olv      = q.method == `TLSP_METHOD_OLV;
    clampNow = olv && (torqueMag > limit);
  end

  // ************************************************************
  // Stall supervision inputs
  // ************************************************************
  always_comb begin
    stallOn = (q.method != `TLSP_METHOD_OLV) && (q.method != `TLSP_METHOD_RSVD)
           && (q.runStallPreventionSelect != `TLSP_SEL_OFF)
           && (q.runStallPreventionSelect <= `TLSP_SEL_DEC2);
    stallLevel = pct({1'b0, q.runStallPreventionLevel});
    if (q.analogInputFunctionSelect == `TLSP_AFN_STALL) begin
      stallLevel = min16(stallLevel, anaScale(analogLevel, q.analogInputGain));
    end
    current   = {4'h0, outputCurrent};
    overLevel = stallOn && (current > stallLevel);
    underHyst = (current + `TLSP_REACCEL_HYST) <= stallLevel;
  end

  tlsp_stall_timer #(
    .CYCLES (STALL_CYCLES)
  ) u_timer (
    .mclk    (mclk),
    .resetn  (resetn),
    .countEn (overLevel && (q.stall != tlsp_pkg::TLSP_LOWER)),
    .expired (timerExpired)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  assign busWrite = avsWrite && !q.waitRequest;

  always_comb begin
    d = q;
    // One wait state: the request is seen, then completes on the next edge.
    d.waitRequest = !((avsRead || avsWrite) && q.waitRequest);
    if (avsRead && q.waitRequest) begin
      unique case (avsAddress)
        `TLSP_ADDR_CTRL:    d.readData = {29'h0, q.duty, q.method};
        `TLSP_ADDR_FWD_DRV: d.readData = {23'h0, q.fwdDriveTorqueLimit};
        `TLSP_ADDR_REV_DRV: d.readData = {23'h0, q.revDriveTorqueLimit};
        `TLSP_ADDR_FWD_RGN: d.readData = {23'h0, q.fwdRegenTorqueLimit};
        `TLSP_ADDR_REV_RGN: d.readData = {23'h0, q.revRegenTorqueLimit};
        `TLSP_ADDR_AFN:     d.readData = {27'h0, q.analogInputFunctionSelect};
        `TLSP_ADDR_GAIN:    d.readData = {20'h0, q.analogInputGain};
        `TLSP_ADDR_STL_SEL: d.readData = {30'h0, q.runStallPreventionSelect};
        `TLSP_ADDR_STL_LVL: d.readData = {24'h0, q.runStallPreventionLevel};
        `TLSP_ADDR_STATUS:  d.readData = {10'h0, q.stallReaccel, q.stallLower,
                                          q.stall, q.limitActive, q.effLimit};
        default:            d.readData = 32'h0;
      endcase
    end
    if (busWrite) begin
      unique case (avsAddress)
        `TLSP_ADDR_CTRL: begin
          d.method = avsWriteData[1:0];
          d.duty   = avsWriteData[2];
          // A duty change reloads the stall level with that duty's default.
          if (avsWriteData[2] != q.duty) begin
            d.runStallPreventionLevel = avsWriteData[2] ? `TLSP_STL_LVL_VT
                                                       : `TLSP_STL_LVL_CT;
          end
        end
        `TLSP_ADDR_FWD_DRV: d.fwdDriveTorqueLimit = (avsWriteData[8:0] > `TLSP_TLIM_MAX)
                                                  ? `TLSP_TLIM_MAX : avsWriteData[8:0];
        `TLSP_ADDR_REV_DRV: d.revDriveTorqueLimit = (avsWriteData[8:0] > `TLSP_TLIM_MAX)
                                                  ? `TLSP_TLIM_MAX : avsWriteData[8:0];
        `TLSP_ADDR_FWD_RGN: d.fwdRegenTorqueLimit = (avsWriteData[8:0] > `TLSP_TLIM_MAX)
                                                  ? `TLSP_TLIM_MAX : avsWriteData[8:0];
        `TLSP_ADDR_REV_RGN: d.revRegenTorqueLimit = (avsWriteData[8:0] > `TLSP_TLIM_MAX)
                                                  ? `TLSP_TLIM_MAX : avsWriteData[8:0];
        `TLSP_ADDR_AFN:     d.analogInputFunctionSelect = avsWriteData[4:0];
        `TLSP_ADDR_GAIN:    d.analogInputGain = avsWriteData[11:0];
        `TLSP_ADDR_STL_SEL: d.runStallPreventionSelect = avsWriteData[1:0];
        `TLSP_ADDR_STL_LVL: begin
          if (avsWriteData[7:0] < `TLSP_STL_LVL_MIN) begin
            d.runStallPreventionLevel = `TLSP_STL_LVL_MIN;
          end else if (avsWriteData[7:0] > `TLSP_STL_LVL_MAX) begin
            d.runStallPreventionLevel = `TLSP_STL_LVL_MAX;
          end else begin
            d.runStallPreventionLevel = avsWriteData[7:0];
          end
        end
        default: ;
      endcase
    end

    d.effLimit    = limit;
    d.limitActive = clampNow;
    if (clampNow) begin
      d.torqueCmd = posTorque ? signed'(limit) : signed'(16'(-limit));
    end else begin
      d.torqueCmd = torqueCalc;
    end

    unique case (q.stall)
      tlsp_pkg::TLSP_IDLE: begin
        if (stallOn && timerExpired) begin
          d.stall = tlsp_pkg::TLSP_LOWER;
        end
      end
      tlsp_pkg::TLSP_LOWER: begin
        if (!stallOn) begin
          d.stall = tlsp_pkg::TLSP_IDLE;
        end else if (underHyst) begin
          d.stall = tlsp_pkg::TLSP_RECOVER;
        end
      end
      tlsp_pkg::TLSP_RECOVER: begin
        if (!stallOn || freqAtSet) begin
          d.stall = tlsp_pkg::TLSP_IDLE;
        end else if (timerExpired) begin
          d.stall = tlsp_pkg::TLSP_LOWER;
        end
      end
      default: d.stall = tlsp_pkg::TLSP_IDLE;
    endcase
    d.stallLower      = d.stall == tlsp_pkg::TLSP_LOWER;
    d.stallReaccel    = d.stall == tlsp_pkg::TLSP_RECOVER;
    d.decelTimeTwoSel = q.runStallPreventionSelect == `TLSP_SEL_DEC2;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q                           <= '0;
      q.method                    <= `TLSP_METHOD_RST;
      q.duty                      <= `TLSP_DUTY_RST;
      q.fwdDriveTorqueLimit       <= `TLSP_TLIM_RST;
      q.revDriveTorqueLimit       <= `TLSP_TLIM_RST;
      q.fwdRegenTorqueLimit       <= `TLSP_TLIM_RST;
      q.revRegenTorqueLimit       <= `TLSP_TLIM_RST;
      q.analogInputFunctionSelect <= `TLSP_AFN_RST;
      q.analogInputGain           <= `TLSP_GAIN_RST;
      q.runStallPreventionSelect  <= `TLSP_STL_SEL_RST;
      q.runStallPreventionLevel   <= `TLSP_STL_LVL_VT;
      q.waitRequest               <= 1'b1;
      q.stall                     <= tlsp_pkg::TLSP_IDLE;
    end else begin
      q <= d;
    end
  end

  assign avsReadData     = q.readData;
  assign avsWaitRequest  = q.waitRequest;
  assign torqueCmd       = q.torqueCmd;
  assign speedCtrlHold   = q.limitActive;
  assign stallLower      = q.stallLower;
  assign stallReaccel    = q.stallReaccel;
  assign decelTimeTwoSel = q.decelTimeTwoSel;

  // ************************************************************
  // Checks
  // ************************************************************
  vf_bypass_a: assert property (@(posedge mclk) disable iff (!resetn)
    !olv |=> torqueCmd == $past(torqueCalc))
    else $error("torque altered outside vector control");

  clamp_exact_a: assert property (@(posedge mclk) disable iff (!resetn)
    clampNow |=> (torqueCmd[15] ? 16'(-torqueCmd) : 16'(torqueCmd)) == $past(limit))
    else $error("clamped torque differs from limit");

  limit_range_a: assert property (@(posedge mclk) disable iff (!resetn)
    q.fwdDriveTorqueLimit <= `TLSP_TLIM_MAX && q.revRegenTorqueLimit <= `TLSP_TLIM_MAX)
    else $error("torque limit above range");

  analog_fwd_a: assert property (@(posedge mclk) disable iff (!resetn)
    olv && posTorque && (q.analogInputFunctionSelect == `TLSP_AFN_POS)
    && (torqueMag > analogLimit) |=> torqueCmd <= signed'($past(analogLimit)))
    else $error("forward analog limit not applied");

  duty_ceiling_a: assert property (@(posedge mclk) disable iff (!resetn)
    olv && posTorque |=> torqueCmd <= signed'($past(ceiling)))
    else $error("torque above duty ceiling");

  speed_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(speedCtrlHold) |-> $past(olv) && torqueCmd != $past(torqueCalc))
    else $error("speed hold without clamping");

  stall_vector_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    olv ##1 olv |-> !stallLower && !stallReaccel)
    else $error("stall action in vector control");

  stall_sel_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (q.runStallPreventionSelect == `TLSP_SEL_OFF) |=> !stallLower)
    else $error("stall lowering while disabled");

  reaccel_hyst_a: assert property (@(posedge mclk) disable iff (!resetn)
    stallLower && stallOn && underHyst |=> stallReaccel && !stallLower)
    else $error("no re-acceleration below hysteresis");

  stall_analog_a: assert property (@(posedge mclk) disable iff (!resetn)
    stallOn && (q.analogInputFunctionSelect == `TLSP_AFN_STALL)
    && (current > analogLimit) |-> overLevel)
    else $error("analog stall level not applied");

  stall_enter_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(stallLower) |-> $past(timerExpired))
    else $error("stall lowering before overload time");

endmodule
`default_nettype wire

// >>> verif/tlsp_motor_model.sv
// Purpose: Behavioural motor load seen by the stall supervisor.
// Assumes: The bench sets the current that the motor load would draw.
// Notes:   Current lags the load by one clock, as a sensed value would.
`timescale 1ns/1ps
`default_nettype none
module tlsp_motor_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [11:0] loadCurrent,
  input  wire logic        stallReaccel,
  output logic [11:0]      outputCurrent,
  output logic             freqAtSet
);
  logic [2:0] reaccelCount;

  // Set frequency is reached a few clocks into re-acceleration, so the
  // recover state is visible before the supervisor leaves it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outputCurrent <= 12'h000;
      reaccelCount  <= 3'h0;
    end else begin
      outputCurrent <= loadCurrent;
      reaccelCount  <= stallReaccel ? reaccelCount + 3'h1 : 3'h0;
    end
  end
  assign freqAtSet = (reaccelCount == 3'h4);
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the torque limit and stall block.
// Assumes: Register map and scaling as set by the block's constants.
// Notes:   Stall timer is shortened to 8 clocks to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STALL = 8;
  logic               mclk = 1'b0;
  logic               resetn = 1'b0;
  logic [3:0]         avsAddress = 4'h0;
  logic               avsRead = 1'b0;
  logic               avsWrite = 1'b0;
  logic [31:0]        avsWriteData = 32'h0;
  logic [31:0]        avsReadData;
  logic               avsWaitRequest;
  logic signed [15:0] torqueCalc = 16'sh0;
  logic               fwdSpin = 1'b1;
  logic [11:0]        analogLevel = 12'h000;
  logic [11:0]        loadCurrent = 12'h000;
  logic [11:0]        outputCurrent;
  logic               freqAtSet;
  logic signed [15:0] torqueCmd;
  logic               speedCtrlHold;
  logic               stallLower;
  logic               stallReaccel;
  logic               decelTimeTwoSel;
  int                 failures = 0;
  int                 testsRun = 0;

  tlsp_torque_stall #(.STALL_CYCLES(STALL)) dut (
    .mclk(mclk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .torqueCalc(torqueCalc), .fwdSpin(fwdSpin),
    .analogLevel(analogLevel), .outputCurrent(outputCurrent), .freqAtSet(freqAtSet),
    .torqueCmd(torqueCmd), .speedCtrlHold(speedCtrlHold), .stallLower(stallLower),
    .stallReaccel(stallReaccel), .decelTimeTwoSel(decelTimeTwoSel));

  tlsp_motor_model motor (
    .mclk(mclk), .resetn(resetn), .loadCurrent(loadCurrent),
    .stallReaccel(stallReaccel), .outputCurrent(outputCurrent), .freqAtSet(freqAtSet));

  always #12.5 mclk = ~mclk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest is sampled at the rising edge; at the edge that sees it low
  // the write lands and read data is taken, and only then is the request
  // released, so the slave never sees a half-finished transfer.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= w;
    avsRead      <= !w;
    do @(posedge mclk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic torq(input int t, input logic f, input int e);
    @(posedge mclk);
    torqueCalc <= 16'(t);
    fwdSpin    <= f;
    @(posedge mclk);
    @(negedge mclk);
    chk(32'(torqueCmd), e);
    chk(speedCtrlHold, e != t);
  endtask

  task automatic load(input logic [11:0] c, input int n);
    @(posedge mclk);
    loadCurrent <= c;
    repeat (n) @(negedge mclk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset_values;
    logic [3:0]  ra [6] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'ha};
    logic [31:0] rv [6] = '{32'h4, 32'hc8, 32'h3e8, 32'h1, 32'h78, 32'h0};
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
  endtask

  task automatic test_quadrants;
    torq(2500, 1'b1, 2500);
    wr(4'h0, 32'h2);
    for (int i = 1; i < 5; i++) wr(4'(i), 32'(90 + 10 * i));
    torq(2000, 1'b1, 1000);
    torq(-2000, 1'b0, -1100);
    torq(-2000, 1'b1, -1200);
    torq(2000, 1'b0, 1300);
    torq(500, 1'b1, 500);
    wr(4'h1, 32'h190);
    rdc(4'h1, 32'h12c);
    for (int i = 2; i < 5; i++) wr(4'(i), 32'h12c);
    torq(2000, 1'b1, 1500);
    wr(4'h0, 32'h6);
    torq(-2000, 1'b0, -1200);
    wr(4'h0, 32'h2);
  endtask

  task automatic test_analog;
    logic [4:0] fn [4] = '{5'h0a, 5'h0b, 5'h0c, 5'h0f};
    logic [3:0] mk [4] = '{4'b1100, 4'b0011, 4'b0101, 4'b1111};
    @(posedge mclk);
    analogLevel <= 12'h300;
    for (int i = 0; i < 4; i++) begin
      wr(4'h5, 32'(fn[i]));
      torq(2000, 1'b1, mk[i][3] ? 500 : 1500);
      torq(2000, 1'b0, mk[i][2] ? 500 : 1500);
      torq(-2000, 1'b0, mk[i][1] ? -500 : -1500);
      torq(-2000, 1'b1, mk[i][0] ? -500 : -1500);
    end
    @(posedge mclk);
    analogLevel <= 12'h500;
    torq(2000, 1'b1, 1000);
    wr(4'h6, 32'h4b0);
    torq(-2000, 1'b0, -1200);
    wr(4'h0, 32'h0);
    torq(2000, 1'b1, 2000);
    wr(4'h5, 32'h0);
  endtask

  task automatic test_stall;
    wr(4'h0, 32'h4);
    rdc(4'h8, 32'h78);
    load(12'h514, STALL);
    chk(stallLower, 1'b0);
    repeat (4) @(negedge mclk);
    chk(stallLower, 1'b1);
    chk(decelTimeTwoSel, 1'b0);
    load(12'h49d, 4);
    chk(stallReaccel, 1'b0);
    load(12'h49c, 3);
    chk(stallReaccel, 1'b1);
    repeat (8) @(negedge mclk);
    chk({stallLower, stallReaccel}, 2'b00);
    wr(4'h7, 32'h2);
    repeat (2) @(negedge mclk);
    chk(decelTimeTwoSel, 1'b1);
    wr(4'h7, 32'h0);
    load(12'h514, 16);
    chk(stallLower, 1'b0);
    wr(4'h0, 32'h6);
    wr(4'h7, 32'h1);
    load(12'h514, 16);
    chk(stallLower, 1'b0);
  endtask

  // An analog level of 500 against the parameter level of 1200 must trip the supervisor
  // at a current that the parameter level alone would let pass.
  task automatic test_analog_stall;
    load(12'h000, 2);
    wr(4'h5, 32'h8);
    wr(4'h6, 32'h3e8);
    @(posedge mclk);
    analogLevel <= 12'h300;
    wr(4'h0, 32'h4);
    load(12'h2bc, STALL);
    chk(stallLower, 1'b0);
    repeat (4) @(negedge mclk);
    chk(stallLower, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    test_reset_values();
    test_quadrants();
    test_analog();
    test_stall();
    test_analog_stall();
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end
endmodule
`default_nettype wire
